// ### hw/sc8b10b_codec.v
// character-level 8b/10b encoder, serializer and decoder
`include "sc8b10b_consts.vh"

module sc8b10b_codec (
  input wire core_clk,
  input wire rst_n,
  input wire [31:0] tx_dword,
  input wire tx_prim,
  input wire tx_valid,
  output reg tx_ready,
  output reg tx_reject,
  output reg tx_bit,
  output reg tx_char_start,
  output reg tx_active,
  input wire [9:0] rx_sym,
  input wire rx_sym_valid,
  output reg [31:0] rx_dword,
  output reg rx_ctl,
  output reg [3:0] rx_viol,
  output reg rx_dword_valid,
  output reg [15:0] viol_count,
  output reg [15:0] disp_err_count
);

  localparam [1:0] ST_IDLE = 2'h1;
  localparam [1:0] ST_SEND = 2'h2;

  // popcount of a 10-bit field
  function [3:0] sc_ones;
    input [9:0] v;
    integer n;
    begin
      sc_ones = 4'h0;
      for (n = 0; n < `SC_SYM_W; n = n + 1)
      begin
        sc_ones = sc_ones + {3'h0, v[n]};
      end
    end
  endfunction

  // returns {rd after, symbol with bit 0 = a sent first}
  function [10:0] sc_enc;
    input [7:0] d;
    input k;
    input rd;
    reg [5:0] c6;
    reg [3:0] c4;
    reg [9:0] m;
    reg [191:0] t6;
    reg [31:0] t4;
    reg rm;
    reg rout;
    integer n;
    begin
      c6 = 6'h00;
      c4 = 4'h0;
      t6 = `SC_TBL6;
      t4 = `SC_TBL4;
      rm = rd;
      if (k)
      begin
        if (d == `SC_K28_5_BYTE)
          m = rd ? `SC_K285_RDP : `SC_K285_RDN;
        else
          m = rd ? `SC_K283_RDP : `SC_K283_RDN;
        rout = ~rd;
      end
      else
      begin
        c6 = t6[`SC_W6 * d[4:0] +: `SC_W6];
        if (rd && (sc_ones({4'h0, c6}) != `SC_BAL6 || d[4:0] == `SC_X_D7))
          c6 = ~c6;
        // sub-block disparity carried into the 4b part
        rm = (sc_ones({4'h0, c6}) == `SC_BAL6) ? rd : ~rd;
        c4 = t4[`SC_W4 * d[7:5] +: `SC_W4];
        if (d[7:5] == `SC_Y_7 && ((!rm && `SC_ALT_RDN(d[4:0])) || (rm && `SC_ALT_RDP(d[4:0]))))
          c4 = `SC_ALT7;
        if (rm && (sc_ones({6'h00, c4}) != `SC_BAL4 || d[7:5] == `SC_Y_3))
          c4 = ~c4;
        rout = (sc_ones({6'h00, c4}) == `SC_BAL4) ? rm : ~rm;
        m = {c6, c4};
      end
      // a..j printed msb first; bit 0 leaves the wire first
      for (n = 0; n < `SC_SYM_W; n = n + 1)
      begin
        sc_enc[n] = m[`SC_SYM_W - 1 - n];
      end
      sc_enc[`SC_SYM_W] = rout;
    end
  endfunction

  // ---------------- transmit ----------------
  reg [1:0] state;
  reg [1:0] next_state;
  reg [31:0] tx_hold;
  reg [31:0] next_tx_hold;
  reg tx_hold_prim;
  reg next_tx_hold_prim;
  reg [1:0] byte_idx;
  reg [1:0] next_byte_idx;
  reg [3:0] bit_cnt;
  reg [3:0] next_bit_cnt;
  reg [9:0] shreg;
  reg [9:0] next_shreg;
  reg tx_rd;
  reg next_tx_rd;
  reg next_tx_bit;
  reg next_tx_char_start;
  reg next_tx_ready;
  reg next_tx_reject;
  reg take;
  reg legal;
  reg [10:0] enc_out;

  always @*
  begin
    next_state = state;
    next_tx_hold = tx_hold;
    next_tx_hold_prim = tx_hold_prim;
    next_byte_idx = byte_idx;
    next_bit_cnt = bit_cnt;
    next_shreg = shreg;
    next_tx_rd = tx_rd;
    next_tx_bit = tx_bit;
    next_tx_char_start = 1'b0;
    next_tx_reject = 1'b0;
    take = tx_ready && tx_valid;
    // only the two legal control characters may open a primitive
    legal = !tx_prim || tx_dword[7:0] == `SC_K28_3_BYTE
      || tx_dword[7:0] == `SC_K28_5_BYTE;
    enc_out = 11'h000;
    case (state)
      ST_IDLE:
      begin
        next_tx_bit = 1'b0;
        if (take && !legal)
          next_tx_reject = 1'b1;
        else if (take)
        begin
          // byte 0 first; control only there
          enc_out = sc_enc(tx_dword[7:0], tx_prim, tx_rd);
          next_tx_hold = tx_dword;
          next_tx_hold_prim = tx_prim;
          next_byte_idx = `SC_BYTE_0;
          next_bit_cnt = 4'h0;
          next_tx_bit = enc_out[0];
          next_shreg = enc_out[9:0] >> 1;
          next_tx_rd = enc_out[`SC_SYM_W];
          next_tx_char_start = 1'b1;
          next_state = ST_SEND;
        end
      end
      ST_SEND:
      begin
        next_tx_bit = shreg[0];
        next_shreg = shreg >> 1;
        next_bit_cnt = bit_cnt + 4'h1;
        if (bit_cnt == `SC_LAST_BIT)
        begin
          next_bit_cnt = 4'h0;
          if (byte_idx != `SC_BYTE_3)
          begin
            // one byte at a time keeps byte order and sub-block disparity
            next_byte_idx = byte_idx + 2'h1;
            enc_out = sc_enc(tx_hold[8 * next_byte_idx +: 8], 1'b0, tx_rd);
            next_tx_bit = enc_out[0];
            next_shreg = enc_out[9:0] >> 1;
            next_tx_rd = enc_out[`SC_SYM_W];
            next_tx_char_start = 1'b1;
          end
          else if (take && legal)
          begin
            // back-to-back Dwords go out in arrival order
            enc_out = sc_enc(tx_dword[7:0], tx_prim, tx_rd);
            next_tx_hold = tx_dword;
            next_tx_hold_prim = tx_prim;
            next_byte_idx = `SC_BYTE_0;
            next_tx_bit = enc_out[0];
            next_shreg = enc_out[9:0] >> 1;
            next_tx_rd = enc_out[`SC_SYM_W];
            next_tx_char_start = 1'b1;
          end
          else
          begin
            next_tx_reject = take;
            next_tx_bit = 1'b0;
            next_state = ST_IDLE;
          end
        end
      end
      default:
      begin
        next_state = ST_IDLE;
      end
    endcase
    next_tx_ready = (next_state == ST_IDLE)
      || (next_byte_idx == `SC_BYTE_3 && next_bit_cnt == `SC_LAST_BIT);
  end

  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= ST_IDLE;
      tx_hold <= 32'h00000000;
      tx_hold_prim <= 1'b0;
      byte_idx <= 2'h0;
      bit_cnt <= 4'h0;
      shreg <= 10'h000;
      tx_rd <= `SC_RD_NEG;
      tx_bit <= 1'b0;
      tx_char_start <= 1'b0;
      tx_ready <= 1'b0;
      tx_reject <= 1'b0;
      tx_active <= 1'b0;
    end
    else
    begin
      state <= next_state;
      tx_hold <= next_tx_hold;
      tx_hold_prim <= next_tx_hold_prim;
      byte_idx <= next_byte_idx;
      bit_cnt <= next_bit_cnt;
      shreg <= next_shreg;
      tx_rd <= next_tx_rd;
      tx_bit <= next_tx_bit;
      tx_char_start <= next_tx_char_start;
      tx_ready <= next_tx_ready;
      tx_reject <= next_tx_reject;
      tx_active <= (next_state == ST_SEND);
    end
  end

  // ---------------- receive ----------------
  reg rx_rd;
  wire [`SC_NCHAR-1:0] hit;
  wire [10:0] k283_exp;
  wire [10:0] k285_exp;

  // one comparator per data character, current column only
  genvar gi;
  generate
    for (gi = 0; gi < `SC_NCHAR; gi = gi + 1)
    begin : g_col
      localparam [7:0] CODE = gi;
      wire [10:0] exp_sym;
      assign exp_sym = sc_enc(CODE, 1'b0, rx_rd);
      assign hit[gi] = (exp_sym[9:0] == rx_sym);
    end
  endgenerate

  assign k283_exp = sc_enc(`SC_K28_3_BYTE, 1'b1, rx_rd);
  assign k285_exp = sc_enc(`SC_K28_5_BYTE, 1'b1, rx_rd);

  reg [7:0] dec_byte;
  reg dec_k;
  reg dec_ok;
  reg [3:0] p6;
  reg [3:0] p4;
  reg rx_mid;
  reg next_rx_rd;
  reg disp_err;
  integer j;

  always @*
  begin
    dec_byte = 8'h00;
    dec_k = 1'b0;
    dec_ok = 1'b0;
    for (j = 0; j < `SC_NCHAR; j = j + 1)
    begin
      if (hit[j])
      begin
        dec_byte = j[7:0];
        dec_ok = 1'b1;
      end
    end
    if (rx_sym == k283_exp[9:0] || rx_sym == k285_exp[9:0])
    begin
      dec_byte = (rx_sym == k285_exp[9:0]) ? `SC_K28_5_BYTE : `SC_K28_3_BYTE;
      dec_k = 1'b1;
      dec_ok = 1'b1;
    end
    // disparity from the received bits, sub-block by sub-block
    p6 = sc_ones({4'h0, rx_sym[5:0]});
    p4 = sc_ones({6'h00, rx_sym[9:6]});
    rx_mid = (p6 > `SC_BAL6) ? 1'b1 : (p6 < `SC_BAL6) ? 1'b0 : rx_rd;
    next_rx_rd = (p4 > `SC_BAL4) ? 1'b1 : (p4 < `SC_BAL4) ? 1'b0 : rx_mid;
    // same-polarity sub-blocks in a row cannot match the column
    disp_err = (p6 > `SC_BAL6 && rx_rd) || (p6 < `SC_BAL6 && !rx_rd)
      || (p4 > `SC_BAL4 && rx_mid) || (p4 < `SC_BAL4 && !rx_mid);
  end

  reg [1:0] rx_idx;
  reg [31:0] rx_acc;
  reg [3:0] rx_vacc;
  reg rx_kacc;

  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_rd <= `SC_RD_NEG;
      rx_idx <= 2'h0;
      rx_acc <= 32'h00000000;
      rx_vacc <= 4'h0;
      rx_kacc <= 1'b0;
      rx_dword <= 32'h00000000;
      rx_ctl <= 1'b0;
      rx_viol <= 4'h0;
      rx_dword_valid <= 1'b0;
      viol_count <= 16'h0000;
      disp_err_count <= 16'h0000;
    end
    else
    begin
      rx_dword_valid <= 1'b0;
      if (rx_sym_valid)
      begin
        rx_rd <= next_rx_rd;
        if (!dec_ok && viol_count != {`SC_CNT_W{1'b1}})
          viol_count <= viol_count + 16'h0001;
        if (disp_err && disp_err_count != {`SC_CNT_W{1'b1}})
          disp_err_count <= disp_err_count + 16'h0001;
        if (dec_k)
        begin
          // a control character always opens a new Dword
          rx_acc <= {24'h000000, dec_byte};
          rx_vacc <= 4'h0;
          rx_kacc <= 1'b1;
          rx_idx <= 2'h1;
        end
        else
        begin
          rx_acc[8 * rx_idx +: 8] <= dec_byte;
          rx_vacc[rx_idx] <= !dec_ok;
          rx_idx <= rx_idx + 2'h1;
          if (rx_idx == `SC_BYTE_0)
            rx_kacc <= 1'b0;
          if (rx_idx == `SC_BYTE_3)
          begin
            rx_dword <= {dec_byte, rx_acc[23:0]};
            rx_viol <= {!dec_ok, rx_vacc[2:0]};
            rx_ctl <= rx_kacc;
            rx_dword_valid <= 1'b1;
          end
        end
      end
    end
  end

endmodule // sc8b10b_codec

// ### hw/sc8b10b_consts.vh
// constants for the character-level 8b/10b codec
// Contract
// - K28.3 (rd- 001111 0011) only as byte 0 of non-ALIGN primitives.
// - K28.5 is 001111 1010 at rd-, 110000 0101 at rd+; ALIGN byte 0.
// - only K28.3 and K28.5 are legal, always as first primitive byte.
// - primitive characters obey normal running-disparity rules, per character and sub-block.
// - both control characters invert the running disparity.
// - a whole ALIGN primitive leaves running disparity unchanged.
// - serial bit order is a b c d e i f g h j.
// - Dword bytes go byte 0 first, byte 3 last; receiver reassembles likewise.
// - frame Dwords go in ascending order: SOF, contents, CRC, EOF.
// - wider datapaths allowed if byte order and sub-block disparity are kept.
// - decode only against the current-disparity column; found symbols pass on.
// - symbols missing from that column are flagged as code violations.
// - receive disparity updates on every character, violations included.
// - disparity evaluated after each 6-bit and 4-bit sub-block, carried forward.
// - same-polarity non-neutral sub-blocks in a row give an invalid character.
// - optionally count disparity errors and code violations for firmware.
// - a primitive is one constant Dword whose first byte is a control character.
`ifndef SC8B10B_CONSTS_VH
`define SC8B10B_CONSTS_VH

`define SC_RD_NEG 1'h0
`define SC_K28_3_BYTE 8'h7C
`define SC_K28_5_BYTE 8'hBC
`define SC_K283_RDN 10'h0F3
`define SC_K283_RDP 10'h30C
`define SC_K285_RDN 10'h0FA
`define SC_K285_RDP 10'h305
// 5b/6b rd- codes, abcdei with a as msb, entry 0 in the low bits
`define SC_TBL6 {6'h2B, 6'h1E, 6'h2E, 6'h0E, 6'h36, 6'h16, 6'h26, 6'h33, \
  6'h3A, 6'h1A, 6'h2A, 6'h0B, 6'h32, 6'h13, 6'h23, 6'h1B, \
  6'h17, 6'h1C, 6'h2C, 6'h0D, 6'h34, 6'h15, 6'h25, 6'h39, \
  6'h38, 6'h19, 6'h29, 6'h35, 6'h31, 6'h2D, 6'h1D, 6'h27}
// 3b/4b rd- codes, fghj with f as msb
`define SC_TBL4 {4'hE, 4'h6, 4'hA, 4'hD, 4'hC, 4'h5, 4'h9, 4'hB}
`define SC_ALT7 4'h7
`define SC_X_D7 5'h07
`define SC_Y_3 3'h3
`define SC_Y_7 3'h7
`define SC_ALT_RDN(x) ((x) == 5'h11 || (x) == 5'h12 || (x) == 5'h14)
`define SC_ALT_RDP(x) ((x) == 5'h0B || (x) == 5'h0D || (x) == 5'h0E)
`define SC_BAL6 4'h3
`define SC_BAL4 4'h2
`define SC_W6 6
`define SC_W4 4
`define SC_SYM_W 10
`define SC_LAST_BIT 4'h9
`define SC_PRELOAD_BIT 4'h8
`define SC_BYTE_0 2'h0
`define SC_BYTE_3 2'h3
`define SC_CNT_W 16
`define SC_NCHAR 256

`endif

// ### testbench/scc_peer.sv
// far node model: gathers line bits into symbols and returns them
module scc_peer (
  input logic core_clk,
  input logic rst_n,
  input logic tx_bit,
  input logic tx_char_start,
  output logic [9:0] sym,
  output logic sym_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] sh;
  logic [3:0] n;
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sh <= 9'h000;
      n <= 4'h0;
      sym <= 10'h000;
      sym_valid <= 1'b0;
    end
    else
    begin
      sh <= {tx_bit, sh[8:1]};
      n <= tx_char_start ? 4'h1 : (n == 4'h9 || n == 4'h0) ? 4'h0 : n + 4'h1;
      sym_valid <= n == 4'h9 && !tx_char_start;
      // bit a lands in bit 0; idle bus inverts
      sym <= (n == 4'h9) ? {tx_bit, sh} : ~sym;
    end
  end
endmodule // scc_peer

// ### testbench/scc_props.sv
// port assertions for the character codec
module scc_props (
  input logic core_clk,
  input logic rst_n,
  input logic [31:0] tx_dword,
  input logic tx_prim,
  input logic tx_valid,
  input logic tx_ready,
  input logic tx_reject,
  input logic tx_bit,
  input logic tx_char_start,
  input logic tx_active,
  input logic [9:0] rx_sym,
  input logic rx_sym_valid,
  input logic [31:0] rx_dword,
  input logic rx_ctl,
  input logic [3:0] rx_viol,
  input logic rx_dword_valid,
  input logic [15:0] viol_count,
  input logic [15:0] disp_err_count
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  wire legal = tx_dword[7:0] == 8'h7C || tx_dword[7:0] == 8'hBC;
  wire rx_legal = rx_dword[7:0] == 8'h7C || rx_dword[7:0] == 8'hBC;
  wire [31:0] vmask = {{8{rx_viol[3]}}, {8{rx_viol[2]}}, {8{rx_viol[1]}}, {8{rx_viol[0]}}};
  sequence good_take;
    tx_valid && tx_ready && (!tx_prim || legal);
  endsequence
  sequence bad_take;
    tx_valid && tx_ready && tx_prim && !legal;
  endsequence
  sequence four_chars;
    tx_char_start ##10 tx_char_start ##10 tx_char_start ##10 tx_char_start;
  endsequence
  a_dword_chars: assert property (good_take |=> four_chars)
    else $error("dword not sent as four characters");
  a_bad_drop: assert property (bad_take |=> tx_reject && !tx_char_start)
    else $error("illegal control byte not dropped");
  a_good_keep: assert property (good_take |=> !tx_reject)
    else $error("legal dword rejected");
  a_char_len: assert property (tx_char_start |=> !tx_char_start [*8] ##1 !tx_char_start)
    else $error("character shorter than ten bits");
  a_busy_hold: assert property (good_take |=> !tx_ready throughout (##36 1))
    else $error("ready raised inside a dword");
  a_idle_low: assert property (!tx_active |-> !tx_bit)
    else $error("line not low while idle");
  a_ctl_prefix: assert property (rx_dword_valid && rx_ctl |-> rx_legal)
    else $error("control flag on a non-prefix byte");
  a_viol_zero: assert property (rx_dword_valid |-> (rx_dword & vmask) == 32'h00000000)
    else $error("violating byte not zero");
  a_count_step: assert property (viol_count != $past(viol_count)
    |-> viol_count == $past(viol_count) + 16'h0001 && $past(rx_sym_valid))
    else $error("violation count stepped wrongly");
  a_rx_answer: assert property (rx_dword_valid |-> $past(rx_sym_valid))
    else $error("dword result without a symbol");
endmodule // scc_props

// ### testbench/testbench.sv
// self-checking bench: codec looped back through the peer model
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [31:0] tx_dword = 32'h00000000;
  logic tx_prim = 1'b0;
  logic tx_valid = 1'b0;
  logic inj = 1'b0;
  logic inj_valid = 1'b0;
  logic [9:0] inj_sym = 10'h000;
  logic tx_ready, tx_reject, tx_bit, tx_char_start, tx_active, rx_ctl, rx_dword_valid;
  logic [31:0] rx_dword;
  logic [3:0] rx_viol;
  logic [15:0] viol_count, disp_err_count;
  logic [9:0] peer_sym, first_sym;
  logic peer_valid;
  logic [1:0] nsym;
  int error_cnt = 0;
  int check_count = 0;
  int cyc = 0;
  wire [9:0] rx_sym = inj ? inj_sym : peer_sym;
  wire rx_sym_valid = inj ? inj_valid : peer_valid;
  sc8b10b_codec DUT (.core_clk, .rst_n, .tx_dword, .tx_prim, .tx_valid, .tx_ready,
    .tx_reject, .tx_bit, .tx_char_start, .tx_active, .rx_sym, .rx_sym_valid, .rx_dword,
    .rx_ctl, .rx_viol, .rx_dword_valid, .viol_count, .disp_err_count);
  scc_peer u_peer (.core_clk, .rst_n, .tx_bit, .tx_char_start, .sym(peer_sym),
    .sym_valid(peer_valid));
  initial forever #2 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    nsym <= !rst_n ? 2'h0 : nsym + {1'b0, peer_valid};
    if (peer_valid && nsym == 2'h0)
      first_sym <= peer_sym;
    cyc++;
    if (cyc == 5000)
    begin
      error_cnt++;
      results();
    end
  end
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic do_reset;
    rst_n <= 1'b0;
    inj <= 1'b0;
    repeat (10) @(posedge core_clk);
    check("reset state", 32'h00000000, {viol_count, disp_err_count});
    rst_n <= 1'b1;
    @(posedge core_clk);
  endtask
  task automatic send(input logic [31:0] d, input logic p);
    int t;
    t = 0;
    tx_dword <= d;
    tx_prim <= p;
    tx_valid <= 1'b1;
    do @(posedge core_clk); while (tx_ready !== 1'b1 && ++t < 100);
    tx_valid <= 1'b0;
  endtask
  // s0 of 3FF skips the first-symbol check
  task automatic loop(input logic [31:0] d, input logic p, input logic [9:0] s0);
    int t;
    t = 0;
    send(d, p);
    do @(posedge core_clk); while (rx_dword_valid !== 1'b1 && ++t < 200);
    check("rx dword", d, rx_dword);
    check("rx ctl", {31'h00000000, p}, {31'h00000000, rx_ctl});
    check("rx viol", 32'h00000000, {28'h0000000, rx_viol});
    if (s0 !== 10'h3FF)
      check("first symbol", {22'h000000, s0}, {22'h000000, first_sym});
  endtask
  task automatic reject_case;
    send(32'h4A4A4A01, 1'b1);
    @(posedge core_clk);
    check("reject", 32'h00000002, {30'h00000000, tx_reject, tx_active});
  endtask
  task automatic inject(input logic [39:0] s, input logic [31:0] d, input logic [3:0] v);
    int i;
    inj <= 1'b1;
    for (i = 0; i < 4; i++)
    begin
      inj_sym <= s[10*i +: 10];
      inj_valid <= 1'b1;
      @(posedge core_clk);
    end
    inj_valid <= 1'b0;
    inj_sym <= ~inj_sym;
    @(posedge core_clk);
    check("inj done", 32'h00000003, {30'h00000000, rx_dword_valid, rx_ctl});
    check("inj dword", d, rx_dword);
    check("inj viol", {28'h0000000, v}, {28'h0000000, rx_viol});
  endtask
  task automatic results;
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    do_reset();
    inject({10'h2AA, 10'h141, 10'h157, 10'h17C}, 32'h4A0000BC, 4'h6);
    check("counts", 32'h00020001, {viol_count, disp_err_count});
    inject({10'h2AA, 10'h2AA, 10'h2AA, 10'h17C}, 32'h4A4A4ABC, 4'h0);
    do_reset();
    loop(32'h7B4A4ABC, 1'b1, 10'h17C);
    loop(32'h7B4A4ABC, 1'b1, 10'h17C);
    loop(32'h4A4A4A7C, 1'b1, 10'h33C);
    reject_case();
    loop(32'h7B4A4ABC, 1'b1, 10'h283);
    loop(32'h04030201, 1'b0, 10'h3FF);
    results();
  end
endmodule // testbench
bind sc8b10b_codec scc_props u_props (.core_clk, .rst_n, .tx_dword, .tx_prim, .tx_valid,
  .tx_ready, .tx_reject, .tx_bit, .tx_char_start, .tx_active, .rx_sym, .rx_sym_valid,
  .rx_dword, .rx_ctl, .rx_viol, .rx_dword_valid, .viol_count, .disp_err_count);
